// ---- rtl/lshr_top.sv ----
// LIN slave header receiver: wake/standby, break, sync, identifier.
// Assumes an AXI4-Lite master on clk and a receive-only bus line.
`timescale 1ns/100ps
module lshr_top #(
  parameter int SETTLE_CYCLES = lshr_pkg::SETTLE_CYC,
  parameter int DRV_DELAY = lshr_pkg::DRV_MIN_CYC,
  parameter int STANDBY_BITS = lshr_pkg::STANDBY_TBIT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus and strap pins
  input wire logic busLine,
  input wire logic rateStrapLo,
  input wire logic rateStrapHi,
  input wire logic nodeAddrBit0,
  input wire logic nodeAddrBit1,
  input wire logic nodeAddrBit2,
  input wire logic nodeAddrBit3,
  // Motor side
  input wire logic motorActive,
  input wire logic cmdAccepted,
  output logic driverStart,
  // Node status
  output logic standby,
  output logic regulatorOn,
  output logic txRequest,
  output logic rxRequest,
  output logic [5:0] rxIdent,
  // AXI4-Lite write
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edges
  logic [6:0] pinSync;
  logic rxLine;
  logic rxPrev;
  logic fallEdge;
  logic riseEdge;
  logic [3:0] nodeAddr;
  logic [1:0] rateSel;

  lshr_sync #(.W(7)) u_pins (
    .clk(clk),
    .reset_n(reset_n),
    .async({busLine, nodeAddrBit3, nodeAddrBit2, nodeAddrBit1,
      nodeAddrBit0, rateStrapHi, rateStrapLo}),
    .synced(pinSync)
  );

  assign rxLine = pinSync[6];
  assign nodeAddr = pinSync[5:2];
  assign rateSel = pinSync[1:0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxPrev <= 1'b1;
    end else begin
      rxPrev <= rxLine;
    end
  end

  assign fallEdge = rxPrev & ~rxLine;
  assign riseEdge = ~rxPrev & rxLine;

  ////////////////////////////////////////////////////////////////////////
  // Bit period selection
  logic [lshr_pkg::PW-1:0] calPeriod;
  logic calValid;
  logic [lshr_pkg::PW-1:0] activePeriod;
  logic hdrTick;
  logic idleTick;

  // Uncalibrated strap rate until a header has succeeded once
  assign activePeriod = calValid ? calPeriod :
    lshr_pkg::nominalPeriod(rateSel);

  lshr_bit_tick u_hdr_tick (
    .clk(clk),
    .reset_n(reset_n),
    .restart(fallEdge | riseEdge),
    .period(activePeriod),
    .tick(hdrTick)
  );

  lshr_bit_tick u_idle_tick (
    .clk(clk),
    .reset_n(reset_n),
    .restart(fallEdge | riseEdge),
    .period(activePeriod),
    .tick(idleTick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Standby, wake and settle
  logic [14:0] idleBits;
  logic [19:0] settleCnt;
  logic settling;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idleBits <= '0;
    end else if (!rxLine || fallEdge || riseEdge) begin
      idleBits <= '0;
    end else if (idleTick && idleBits != 15'(STANDBY_BITS)) begin
      idleBits <= 15'(idleBits + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      standby <= 1'b0;
    end else if (standby) begin
      if (!rxLine) begin
        standby <= 1'b0;
      end
    end else if (idleBits == 15'(STANDBY_BITS) && rxLine) begin
      standby <= ~motorActive;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regulatorOn <= 1'b0;
    end else begin
      regulatorOn <= ~standby;
    end
  end

  // Restarted on every wake so early commands are dropped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settleCnt <= 20'(SETTLE_CYCLES);
    end else if (standby) begin
      settleCnt <= 20'(SETTLE_CYCLES);
    end else if (settleCnt != 20'h0) begin
      settleCnt <= 20'(settleCnt - 1'b1);
    end
  end

  // Reset itself counts as a wake, so settle after reset too
  logic resetSeen;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resetSeen <= 1'b1;
    end else begin
      resetSeen <= 1'b0;
    end
  end

  assign settling = resetSeen | (settleCnt != 20'h0);

  ////////////////////////////////////////////////////////////////////////
  // Header receiver
  lshr_pkg::lshr_hdr_state_t hdrState;
  logic [3:0] tickCnt;
  logic [1:0] fallCnt;
  logic [19:0] measCnt;
  logic [lshr_pkg::PW-1:0] tentPeriod;
  logic [lshr_pkg::PW-1:0] bitCnt;
  logic [3:0] bitIdx;
  logic [9:0] shReg;
  logic frameDone;
  logic rxEnable;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hdrState <= lshr_pkg::HDR_IDLE;
      tickCnt <= '0;
      fallCnt <= '0;
      measCnt <= '0;
      tentPeriod <= '0;
      bitCnt <= '0;
      bitIdx <= '0;
      shReg <= '0;
      frameDone <= 1'b0;
    end else begin
      frameDone <= 1'b0;
      if (hdrTick && tickCnt != 4'hf) begin
        tickCnt <= 4'(tickCnt + 1'b1);
      end
      if (standby) begin
        hdrState <= lshr_pkg::HDR_IDLE;
      end else begin
        unique case (hdrState)
          lshr_pkg::HDR_IDLE: begin
            if (fallEdge && rxEnable) begin
              hdrState <= lshr_pkg::HDR_BREAK;
              tickCnt <= '0;
            end
          end
          lshr_pkg::HDR_BREAK: begin
            if (riseEdge) begin
              tickCnt <= '0;
              if (tickCnt >= lshr_pkg::BREAK_TBIT) begin
                hdrState <= lshr_pkg::HDR_GAP;
              end else begin
                hdrState <= lshr_pkg::HDR_IDLE;
              end
            end
          end
          lshr_pkg::HDR_GAP: begin
            if (fallEdge) begin
              measCnt <= 20'h1;
              fallCnt <= '0;
              if (tickCnt >= lshr_pkg::GAP_MIN_TBIT) begin
                hdrState <= lshr_pkg::HDR_SYNC;
              end else begin
                hdrState <= lshr_pkg::HDR_IDLE;
              end
            end else if (tickCnt >= lshr_pkg::GAP_MAX_TBIT) begin
              hdrState <= lshr_pkg::HDR_IDLE;
            end
          end
          lshr_pkg::HDR_SYNC: begin
            if (measCnt != 20'hfffff) begin
              measCnt <= 20'(measCnt + 1'b1);
            end else begin
              hdrState <= lshr_pkg::HDR_IDLE;
            end
            if (fallEdge) begin
              fallCnt <= 2'(fallCnt + 1'b1);
              if (fallCnt == lshr_pkg::SYNC_FALLS) begin
                // Eight bit times measured, keep one eighth
                tentPeriod <= measCnt[19:3];
                tickCnt <= '0;
                hdrState <= lshr_pkg::HDR_IDWAIT;
              end
            end
          end
          lshr_pkg::HDR_IDWAIT: begin
            if (fallEdge) begin
              bitCnt <= '0;
              bitIdx <= '0;
              hdrState <= lshr_pkg::HDR_IDBITS;
            end else if (tickCnt >= lshr_pkg::GAP_MAX_TBIT) begin
              hdrState <= lshr_pkg::HDR_IDLE;
            end
          end
          lshr_pkg::HDR_IDBITS: begin
            bitCnt <= lshr_pkg::PW'(bitCnt + 1'b1);
            if (bitCnt == (tentPeriod >> 1)) begin
              shReg[bitIdx] <= rxLine;
            end
            if (bitCnt >= lshr_pkg::PW'(tentPeriod - 1'b1)) begin
              bitCnt <= '0;
              bitIdx <= 4'(bitIdx + 1'b1);
              if (bitIdx == lshr_pkg::ID_LAST_BIT) begin
                frameDone <= 1'b1;
                hdrState <= lshr_pkg::HDR_IDLE;
              end
            end
          end
          default: hdrState <= lshr_pkg::HDR_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Identifier evaluation
  lshr_pkg::lshr_idframe_t frame;
  logic framingOk;
  logic parityOk;
  logic addrHit;
  logic addressed;
  logic accepted;

  assign frame = shReg;
  assign framingOk = ~frame.startBit & frame.stopBit;
  assign parityOk =
    (frame.parityBitA == (frame.nodeAddr[0] ^ frame.nodeAddr[1] ^
      frame.nodeAddr[2] ^ frame.directionBit)) &&
    (frame.parityBitB == ~(frame.nodeAddr[1] ^ frame.nodeAddr[3] ^
      frame.directionBit ^ frame.lengthBit));
  assign addrHit = frame.nodeAddr == nodeAddr;
  assign addressed = addrHit & ~frame.lengthBit;
  assign accepted = frameDone & framingOk & parityOk & addressed &
    ~settling;

  // Only a clean, addressed header recalibrates
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      calPeriod <= '0;
      calValid <= 1'b0;
    end else if (accepted) begin
      calPeriod <= tentPeriod;
      calValid <= 1'b1;
    end
  end

  logic rxMode;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxMode <= 1'b0;
      txRequest <= 1'b0;
      rxRequest <= 1'b0;
      rxIdent <= '0;
    end else begin
      txRequest <= accepted & ~frame.directionBit;
      rxRequest <= accepted & frame.directionBit;
      if (accepted) begin
        rxMode <= frame.directionBit;
        rxIdent <= {frame.lengthBit, frame.directionBit, frame.nodeAddr};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Motor driver start delay
  logic [16:0] drvCnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drvCnt <= '0;
      driverStart <= 1'b0;
    end else begin
      driverStart <= drvCnt == 17'h1;
      if (standby) begin
        drvCnt <= '0;
      end else if (cmdAccepted) begin
        drvCnt <= 17'(DRV_DELAY);
      end else if (drvCnt != 17'h0) begin
        drvCnt <= 17'(drvCnt - 1'b1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic awHeld;
  logic wHeld;
  logic [31:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrFire;
  logic wrCtrl;
  logic wrStatus;
  logic parityErr;
  logic checksumErr;
  lshr_pkg::lshr_status_t status;

  assign awready = ~awHeld & ~bvalid;
  assign wready = ~wHeld & ~bvalid;
  assign arready = ~rvalid;
  assign wrFire = awHeld & wHeld & ~bvalid;
  assign wrCtrl = wrFire & wrStrb[0] & (wrAddr == lshr_pkg::CTRL_OFS);
  assign wrStatus = wrFire & wrStrb[0] & (wrAddr == lshr_pkg::STATUS_OFS);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrAddr <= '0;
      wrData <= '0;
      wrStrb <= '0;
      bvalid <= 1'b0;
      bresp <= lshr_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        wrAddr <= {awaddr[31:2], 2'h0};
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (wrAddr <= lshr_pkg::CAL_OFS) ? lshr_pkg::RESP_OKAY :
          lshr_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxEnable <= lshr_pkg::CTRL_RST;
    end else if (wrCtrl) begin
      rxEnable <= wrData[lshr_pkg::CTRL_EN_POS];
    end
  end

  // Hardware set wins over a same-cycle write-one-to-clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      parityErr <= 1'b0;
      checksumErr <= 1'b0;
    end else begin
      if (frameDone && !framingOk) begin
        parityErr <= 1'b1;
        checksumErr <= 1'b1;
      end else if (frameDone && !parityOk && addressed) begin
        parityErr <= 1'b1;
      end else if (wrStatus) begin
        if (wrData[lshr_pkg::ST_PERR_POS]) begin
          parityErr <= 1'b0;
        end
        if (wrData[lshr_pkg::ST_CERR_POS]) begin
          checksumErr <= 1'b0;
        end
      end
    end
  end

  assign status = '{settling: settling, rxMode: rxMode,
    calValid: calValid, standby: standby,
    checksumErr: checksumErr, parityErr: parityErr};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= lshr_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= lshr_pkg::RESP_OKAY;
      unique case ({araddr[31:2], 2'h0})
        lshr_pkg::CTRL_OFS: rdata <= 32'(rxEnable);
        lshr_pkg::STATUS_OFS: rdata <= 32'(status);
        lshr_pkg::IDENT_OFS: rdata <= 32'(shReg);
        lshr_pkg::CAL_OFS: rdata <= 32'(calPeriod);
        default: begin
          rdata <= '0;
          rresp <= lshr_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // lshr_top

// ---- rtl/lshr_pkg.sv ----
// Shared constants and types for the LIN slave header receiver.
// Assumes a 100 MHz system clock and an AXI4-Lite register slave.
package lshr_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_HZ = 100000000;
  localparam int CLK_NS = 10;
  localparam int SETTLE_NS = 7500000;
  localparam int SETTLE_CYC = SETTLE_NS / CLK_NS;
  localparam int DRV_MIN_NS = 416000;
  localparam int DRV_MAX_NS = 1250000;
  localparam int DRV_MIN_CYC = (DRV_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DRV_MAX_CYC = DRV_MAX_NS / CLK_NS;
  localparam int STANDBY_TBIT = 25000;
  localparam logic [3:0] BREAK_TBIT = 4'h b;
  localparam logic [3:0] GAP_MIN_TBIT = 4'h1;
  localparam logic [3:0] GAP_MAX_TBIT = 4'hd;
  localparam logic [1:0] SYNC_FALLS = 2'h3;
  localparam logic [3:0] ID_LAST_BIT = 4'h9;
  localparam int RATE_0 = 2400;
  localparam int RATE_1 = 4800;
  localparam int RATE_2 = 9600;
  localparam int RATE_3 = 19200;
  localparam int PW = 17;

  ////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
  localparam logic [31:0] IDENT_OFS = 32'h0000_0008;
  localparam logic [31:0] CAL_OFS = 32'h0000_000c;
  localparam logic CTRL_RST = 1'h1;
  localparam int CTRL_EN_POS = 0;
  localparam int ST_PERR_POS = 0;
  localparam int ST_CERR_POS = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    HDR_IDLE = 3'h0,
    HDR_BREAK = 3'h1,
    HDR_GAP = 3'h3,
    HDR_SYNC = 3'h2,
    HDR_IDWAIT = 3'h6,
    HDR_IDBITS = 3'h7
  } lshr_hdr_state_t;

  typedef struct packed {
    logic settling;
    logic rxMode;
    logic calValid;
    logic standby;
    logic checksumErr;
    logic parityErr;
  } lshr_status_t;

  typedef struct packed {
    logic stopBit;
    logic parityBitB;
    logic parityBitA;
    logic lengthBit;
    logic directionBit;
    logic [3:0] nodeAddr;
    logic startBit;
  } lshr_idframe_t;

  ////////////////////////////////////////////////////////////////////////
  // Nominal bit period in clocks from the rate straps {hi, lo}
  function automatic logic [PW-1:0] nominalPeriod(input logic [1:0] sel);
    unique case (sel)
      2'h0: nominalPeriod = PW'(CLK_HZ / RATE_0);
      2'h1: nominalPeriod = PW'(CLK_HZ / RATE_1);
      2'h2: nominalPeriod = PW'(CLK_HZ / RATE_2);
      2'h3: nominalPeriod = PW'(CLK_HZ / RATE_3);
    endcase
  endfunction

endpackage

// ---- rtl/lshr_sync.sv ----
// Two-stage synchroniser for asynchronous pin inputs.
// Assumes inputs are quasi-static or slow against the clock.
`timescale 1ns/100ps
module lshr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '1;
      synced <= '1;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule // lshr_sync

// ---- rtl/lshr_bit_tick.sv ----
// Bit-time enable generator: one pulse per programmed period.
// Assumes period is at least two clocks; restart realigns the phase.
`timescale 1ns/100ps
module lshr_bit_tick (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic restart,
  input wire logic [lshr_pkg::PW-1:0] period,
  // Enable out
  output logic tick
);

  logic [lshr_pkg::PW-1:0] cnt;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (restart) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt >= lshr_pkg::PW'(period - 1'b1)) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= lshr_pkg::PW'(cnt + 1'b1);
      tick <= 1'b0;
    end
  end

endmodule // lshr_bit_tick

// ---- verification/lshr_top_assertions.sv ----
// Assertions on the ports of the LIN slave header receiver.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/100ps
module lshr_top_assertions #(
  parameter int DRV_DELAY = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus and motor side
  input wire logic busLine,
  input wire logic motorActive,
  input wire logic cmdAccepted,
  input wire logic driverStart,
  // Node status
  input wire logic standby,
  input wire logic regulatorOn,
  input wire logic txRequest,
  input wire logic rxRequest,
  input wire logic [5:0] rxIdent
);
  localparam int DRV_WAIT = DRV_DELAY + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////
  sequence s_driverOn;
    ##DRV_WAIT driverStart;
  endsequence
  sequence s_txDone;
    !rxRequest ##1 (!txRequest && rxIdent[5:4] == 2'h0);
  endsequence
  sequence s_rxDone;
    !txRequest ##1 (!rxRequest && rxIdent[5:4] == 2'h1);
  endsequence
  a_reg_tracks: assert property (
    $past(reset_n) |-> regulatorOn == !$past(standby))
    else $error("regulator not inverse of standby");
  a_low_wakes: assert property ((!busLine) [*4] |=> !standby)
    else $error("standby with bus held low");
  // Two synchroniser stages keep standby up for two more edges
  a_sync_stages: assert property (
    $fell(busLine) && standby |=> standby [*2])
    else $error("bus low reached logic too early");
  a_motor_defers: assert property (
    motorActive && !standby |=> !standby)
    else $error("standby while motor active");
  a_driver_delay: assert property (cmdAccepted |-> s_driverOn)
    else $error("driver start late or missing");
  a_driver_cause: assert property (
    driverStart |-> $past(cmdAccepted, DRV_WAIT))
    else $error("driver start without command");
  a_tx_ident: assert property (txRequest |-> s_txDone)
    else $error("transmit request with wrong ident");
  a_rx_ident: assert property (rxRequest |-> s_rxDone)
    else $error("receive request with wrong ident");
endmodule // lshr_top_assertions

bind lshr_top lshr_top_assertions #(.DRV_DELAY(DRV_DELAY)) u_chk (
  .clk(clk), .reset_n(reset_n), .busLine(busLine),
  .motorActive(motorActive), .cmdAccepted(cmdAccepted),
  .driverStart(driverStart), .standby(standby), .regulatorOn(regulatorOn),
  .txRequest(txRequest), .rxRequest(rxRequest), .rxIdent(rxIdent));

// ---- verification/lshr_lin_master.sv ----
// LIN master model: break, sync and identifier on the bus line.
// Assumes a pulled-up line, so it idles high between frames.
`timescale 1ns/100ps
module lshr_lin_master #(
  parameter int NOM = 5208
) (
  // Clock
  input wire logic clk,
  // Bus
  output logic busLine
);
  initial busLine = 1'h1;
  ////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] idFrame(input logic [5:0] id);
    logic a;
    logic b;
    a = id[0] ^ id[1] ^ id[2] ^ id[4];
    b = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {1'h1, b, a, id, 1'h0};
  endfunction
  task automatic hold(input logic v, input int n);
    busLine <= v;
    repeat (n) @(posedge clk);
  endtask
  // Sync and ident run faster than nominal so recalibration shows
  // Break and delimiter scale with the period the slave times against
  task automatic header(input logic [9:0] idf, input int bitClk,
    input int refClk);
    logic [9:0] syn;
    syn = {1'h1, 8'h55, 1'h0};
    hold(1'h0, refClk * 23 / 2);
    hold(1'h1, refClk * 3 / 2);
    for (int i = 0; i < 10; i++) hold(syn[i], bitClk);
    for (int i = 0; i < 10; i++) hold(idf[i], bitClk);
  endtask
endmodule // lshr_lin_master

// ---- verification/lshr_top_tb.sv ----
// Bench for the LIN slave header receiver: headers, registers, standby.
// Assumes the master model drives the bus; straps select 19200 bps.
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module lshr_top_tb;
  localparam int DRV = 20;
  logic clk, reset_n, motorActive, cmdAccepted;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] addr, strb;
  logic [1:0] rate;
  logic [31:0] awaddr, wdata, araddr, rd;
  logic [1:0] rs;
  wire logic busLine, driverStart, standby, regulatorOn, txRequest;
  wire logic rxRequest, awready, wready, bvalid, arready, rvalid;
  wire logic [5:0] rxIdent;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int n_errors, compares, cycles, nTx, nRx;

  lshr_top #(.SETTLE_CYCLES(200), .DRV_DELAY(DRV), .STANDBY_BITS(16)) u_dut (
    .clk(clk), .reset_n(reset_n), .busLine(busLine),
    .rateStrapLo(rate[0]), .rateStrapHi(rate[1]), .nodeAddrBit0(addr[0]),
    .nodeAddrBit1(addr[1]), .nodeAddrBit2(addr[2]), .nodeAddrBit3(addr[3]),
    .motorActive(motorActive), .cmdAccepted(cmdAccepted),
    .driverStart(driverStart), .standby(standby), .regulatorOn(regulatorOn),
    .txRequest(txRequest), .rxRequest(rxRequest), .rxIdent(rxIdent),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(strb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  lshr_lin_master u_master (.clk(clk), .busLine(busLine));
  ////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Handshakes are looked at on the falling edge, where they are settled
  task automatic axiWr(input logic [31:0] a, input logic [31:0] d);
    logic aOk, wOk, bOk;
    bOk = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!bOk) begin
      @(negedge clk);
      aOk = awvalid && awready === 1'h1;
      wOk = wvalid && wready === 1'h1;
      bOk = bvalid === 1'h1;
      rs = bresp;
      @(posedge clk);
      if (aOk) awvalid <= 1'h0;
      if (wOk) wvalid <= 1'h0;
      if (bOk) bready <= 1'h0;
    end
  endtask
  task automatic axiRd(input logic [31:0] a);
    logic aOk, rOk;
    rOk = 1'h0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!rOk) begin
      @(negedge clk);
      aOk = arvalid && arready === 1'h1;
      rOk = rvalid === 1'h1;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
      if (aOk) arvalid <= 1'h0;
      if (rOk) rready <= 1'h0;
    end
  endtask
  task automatic chkReg(input logic [31:0] a, input logic [31:0] e);
    axiRd(a);
    `CHK(rd, e)
    `CHK(rs, lshr_pkg::RESP_OKAY)
  endtask
  task automatic sendHdr(input logic [9:0] f, input int bitClk,
    input int refClk);
    @(posedge clk);
    u_master.header(f, bitClk, refClk);
    repeat (50) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_driver();
    int n;
    n = 1;
    @(posedge clk);
    cmdAccepted <= 1'h1;
    @(posedge clk);
    cmdAccepted <= 1'h0;
    @(negedge clk);
    while (driverStart !== 1'h1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    `CHK(n, DRV + 1)
  endtask
  task automatic t_reset();
    repeat (300) @(posedge clk);
    chkReg(lshr_pkg::STATUS_OFS, 32'h0);
    chkReg(lshr_pkg::CAL_OFS, 32'h0);
    chkReg(lshr_pkg::CTRL_OFS, 32'h1);
    `CHK(regulatorOn, 1'h1)
    axiRd(32'h10);
    `CHK(rs, lshr_pkg::RESP_SLVERR)
    `CHK(rd, 32'h0)
    axiWr(32'h10, 32'h1);
    `CHK(rs, lshr_pkg::RESP_SLVERR)
    strb <= 4'he;
    axiWr(lshr_pkg::CTRL_OFS, 32'h0);
    chkReg(lshr_pkg::CTRL_OFS, 32'h1);
    strb <= 4'hf;
  endtask
  task automatic t_tx();
    int t0;
    t0 = nTx;
    sendHdr(u_master.idFrame(6'h05), 200, u_master.NOM);
    `CHK(nTx, t0 + 1)
    `CHK(rxIdent, 6'h05)
    chkReg(lshr_pkg::CAL_OFS, 32'hc8);
    chkReg(lshr_pkg::IDENT_OFS, {22'h0, u_master.idFrame(6'h05)});
    chkReg(lshr_pkg::STATUS_OFS, 32'h8);
  endtask
  task automatic t_rx();
    int t0, r0;
    t0 = nTx;
    r0 = nRx;
    sendHdr(u_master.idFrame(6'h15), 250, 200);
    `CHK(nRx, r0 + 1)
    `CHK(nTx, t0)
    `CHK(rxIdent, 6'h15)
    chkReg(lshr_pkg::CAL_OFS, 32'hfa);
    chkReg(lshr_pkg::STATUS_OFS, 32'h18);
  endtask
  task automatic t_bad();
    int t0;
    t0 = nTx;
    sendHdr(u_master.idFrame(6'h05) ^ 10'h080, 300, 250);
    `CHK(nTx, t0)
    `CHK(rxIdent, 6'h15)
    chkReg(lshr_pkg::STATUS_OFS, 32'h19);
    chkReg(lshr_pkg::CAL_OFS, 32'hfa);
    axiWr(lshr_pkg::STATUS_OFS, 32'h1);
    chkReg(lshr_pkg::STATUS_OFS, 32'h18);
    axiWr(lshr_pkg::CAL_OFS, 32'h0);
    chkReg(lshr_pkg::CAL_OFS, 32'hfa);
  endtask
  task automatic t_standby();
    int n;
    n = 0;
    @(posedge clk);
    motorActive <= 1'h1;
    repeat (6000) @(posedge clk);
    @(negedge clk);
    `CHK(standby, 1'h0)
    @(posedge clk);
    motorActive <= 1'h0;
    while (standby !== 1'h1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    `CHK(standby, 1'h1)
    @(negedge clk);
    `CHK(regulatorOn, 1'h0)
    @(posedge clk);
    u_master.hold(1'h0, 20);
    @(negedge clk);
    `CHK(standby, 1'h0)
    `CHK(regulatorOn, 1'h1)
    @(posedge clk);
    u_master.hold(1'h1, 400);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    cycles++;
    if (txRequest === 1'h1) nTx++;
    if (rxRequest === 1'h1) nRx++;
    if (cycles == 120000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    reset_n = 1'h0;
    motorActive = 1'h0;
    cmdAccepted = 1'h0;
    addr = 4'h5;
    rate = 2'h3;
    strb = 4'hf;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    t_driver();
    t_reset();
    t_tx();
    t_rx();
    t_bad();
    t_standby();
    end_sim();
  end
endmodule // lshr_top_tb
